/* File: bench/fpse_lop_model.sv */
`default_nettype none
module fpse_lop_model
    import fpse_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             lock_req,
    input  wire logic             cop_unlock,
    input  wire logic             lop_rd_en,
    input  wire logic             lop_wr_en,
    input  wire logic [LOP_W-1:0] lop_wr_data,
    output logic      [LOP_W-1:0] lop_rd_data,
    output logic                  cop_locked,
    output logic      [LOP_W-1:0] lop_reg,
    output logic                  order_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold_cnt;
    // Coprocessor side: the opcode register, its lock, and a read port valid for two cycles.
    always_ff @(posedge mclk) begin
        if (reset) begin
            lop_reg <= 16'h0F0F;
            cop_locked <= 1'b0;
            order_err <= 1'b0;
            hold_cnt <= 2'h0;
            lop_rd_data <= 16'h5A5A;
        end else begin
            if (lop_wr_en) lop_reg <= lop_wr_data;
            if (lock_req) cop_locked <= 1'b1;
            else if (cop_unlock) cop_locked <= 1'b0;
            if (lop_rd_en && cop_locked) order_err <= 1'b1;
            if (lop_rd_en) begin
                lop_rd_data <= lop_reg;
                hold_cnt <= 2'h2;
            end else if (hold_cnt != 2'h0) begin
                hold_cnt <= hold_cnt - 2'h1;
                // Stale data is scrambled once the hold time runs out.
                if (hold_cnt == 2'h1) lop_rd_data <= ~lop_rd_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp); \
        end \
    end
module testbench
    import fpse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, reset = 1, accel_advanced = 0, lock_req = 0;
    logic status_wr_en = 0, status_rd_en = 0, op_valid = 0, op_sign = 0, op_cmp_valid = 0;
    logic [3:0] status_wr_set = 0, status_rd_set = 0, op_set = 0, parity_set = 0, mc_irq_set;
    logic [31:0] status_wr_data = 0, op_raw_result = 0, status_rd_data, result_data;
    logic [2:0] op_code = 0;
    logic [1:0] op_cmp = 0;
    logic [5:0] op_dest = 0, result_dest;
    logic parity_event = 0, cop_present = 1, op_privileged = 0, op_load_store = 1;
    logic emul_present = 1, null_service_call = 0, cop_locked, order_err;
    logic [7:0] mbox_code = 0;
    logic [15:0] mbox_opcode_in = 0, mbox_opcode_out, lop_rd_data, lop_wr_data, lop_reg;
    logic status_rd_valid, result_wr_en, mc_irq, fp_error, mbox_done, cop_unlock;
    logic lop_rd_en, lop_wr_en;
    logic [31:0] w;
    int failures = 0, cmp_count = 0, cyc = 0, n1, n2;
    // Design under test with its coprocessor model on the far side.
    fp_status_exception_unit dut_u (.mclk, .reset, .accel_advanced, .status_wr_en,
        .status_wr_set, .status_wr_data, .status_rd_en, .status_rd_set, .status_rd_data,
        .status_rd_valid, .op_valid, .op_set, .op_code, .op_sign, .op_cmp_valid, .op_cmp,
        .op_raw_result, .op_dest, .parity_event, .parity_set, .cop_present, .cop_locked,
        .op_privileged, .op_load_store, .emul_present, .result_wr_en, .result_data,
        .result_dest, .mc_irq, .mc_irq_set, .fp_error, .null_service_call, .mbox_code,
        .mbox_opcode_in, .mbox_opcode_out, .mbox_done, .cop_unlock, .lop_rd_en,
        .lop_rd_data, .lop_wr_en, .lop_wr_data);
    fpse_lop_model model_u (.mclk, .reset, .lock_req, .cop_unlock, .lop_rd_en, .lop_wr_en,
        .lop_wr_data, .lop_rd_data, .cop_locked, .lop_reg, .order_err);
    // Clock and hang guard.
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] s, input logic [31:0] d);
        @(posedge mclk);
        status_wr_en <= 1'b1;
        status_wr_set <= s;
        status_wr_data <= d;
        @(posedge mclk);
        status_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] s);
        @(posedge mclk);
        status_rd_en <= 1'b1;
        status_rd_set <= s;
        @(posedge mclk);
        status_rd_en <= 1'b0;
        #1 `CHK(status_rd_valid, 1'b1, "read valid")
        w = status_rd_data;
    endtask
    task automatic op(input logic [3:0] s, input logic [2:0] c, input logic sg);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_set <= s;
        op_code <= c;
        op_sign <= sg;
        op_raw_result <= 32'h3F80_0000;
        op_dest <= 6'h2A;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
    endtask
    task automatic outs(input logic wv, input logic iv, input logic ev);
        `CHK(result_wr_en, wv, "result write")
        `CHK(mc_irq, iv, "irq")
        `CHK(fp_error, ev, "error")
    endtask
    task automatic mb(input logic [7:0] c, input logic [15:0] v, output int n);
        @(posedge mclk);
        null_service_call <= 1'b1;
        mbox_code <= c;
        mbox_opcode_in <= v;
        @(posedge mclk);
        null_service_call <= 1'b0;
        n = 1;
        #1;
        while (mbox_done !== 1'b1 && n < 9) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask
    // Status word write, reset value and per-set separation.
    task automatic t_status();
        for (int i = 0; i < 16; i++) begin
            rd(i[3:0]);
            `CHK(w, STATUS_RESET, "reset word")
        end
        wr(4'h3, (w & 32'hEFFF_FFFF) | 32'h0980_0002);
        rd(4'h3);
        `CHK(w, 32'h1180_0000, "forced bits")
        rd(4'h4);
        `CHK(w, STATUS_RESET, "other set")
        $display("test status done");
    endtask
    // Untrapped and trapped divide-by-zero.
    task automatic t_divz();
        op(4'h1, LOP_DIVZ, 1'b1);
        outs(1'b1, 1'b0, 1'b0);
        `CHK(result_data, 32'hFF80_0000, "signed inf")
        `CHK(result_dest, 6'h2A, "dest")
        rd(4'h1);
        `CHK(w, 32'h7000_0012, "divz word")
        op(4'h1, LOP_NONE, 1'b0);
        rd(4'h1);
        `CHK(w, 32'h1000_0012, "sticky")
        wr(4'h2, 32'h1000_0021);
        op(4'h2, LOP_DIVZ, 1'b0);
        outs(1'b0, 1'b1, 1'b0);
        `CHK(mc_irq_set, 4'h2, "irq set")
        rd(4'h2);
        `CHK(w, 32'h7008_0032, "trap word")
        op(4'h2, LOP_DIVZ, 1'b0);
        outs(1'b1, 1'b0, 1'b0);
        $display("test divide done");
    endtask
    // Rounding modes, quiet NaN, last-operation codes and parity flag.
    task automatic t_modes();
        logic [31:0] ov[4] = '{FP_INF, FP_MAXF, FP_INF, FP_MAXF};
        for (int m = 0; m < 4; m++) begin
            wr(4'h6, STATUS_RESET | (32'(m) << 23));
            op(4'h6, LOP_OVER, 1'b0);
            `CHK(result_data, ov[m], "overflow default")
        end
        op(4'h6, LOP_INVALID, 1'b0);
        `CHK(result_data, FP_QNAN, "quiet nan")
        rd(4'h6);
        `CHK(w[ST_INV], 1'b1, "invalid flag")
        for (int k = 0; k < 8; k++) begin
            op(4'h7, k[2:0], 1'b0);
            rd(4'h7);
            `CHK(w[31:29], (k == 4) ? LOP_ILLEGAL : k[2:0], "last op")
        end
        // The advanced accelerator keeps the DMA parity code as it is.
        @(posedge mclk);
        accel_advanced <= 1'b1;
        op(4'h7, LOP_DMAPAR, 1'b0);
        rd(4'h7);
        `CHK(w[31:29], LOP_DMAPAR, "advanced parity code")
        @(posedge mclk);
        parity_event <= 1'b1;
        parity_set <= 4'h5;
        @(posedge mclk);
        parity_event <= 1'b0;
        rd(4'h5);
        `CHK(w, 32'h1004_0000, "parity")
        $display("test modes done");
    endtask
    // Every fault cause leaves the status untouched.
    task automatic t_fault();
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk);
            {cop_present, op_privileged, op_load_store, emul_present} <= 4'b1011 ^ (4'h8 >> k);
            lock_req <= (k == 4);
            op(4'h8, LOP_DIVZ, 1'b0);
            outs(1'b0, 1'b0, 1'b1);
        end
        @(posedge mclk);
        {cop_present, op_privileged, op_load_store, emul_present} <= 4'b1011;
        lock_req <= 1'b0;
        rd(4'h8);
        `CHK(w, STATUS_RESET, "untouched")
        $display("test fault done");
    endtask
    // Mailbox fetch while locked, then swap once unlocked.
    task automatic t_mbox();
        mb(MBOX_FETCH, 16'h0000, n1);
        `CHK(mbox_opcode_out, 16'h0F0F, "fetch")
        `CHK(lop_reg, 16'h0F0F, "no write")
        `CHK({cop_locked, order_err}, 2'b00, "unlock first")
        mb(MBOX_SWAP, 16'hABCD, n2);
        `CHK(mbox_opcode_out, 16'h0F0F, "swap old")
        `CHK(lop_reg, 16'hABCD, "swap new")
        `CHK(n1, n2 + 1, "unlock latency")
        $display("test mailbox done");
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_status();
        t_divz();
        t_modes();
        t_fault();
        t_mbox();
        conclude();
    end
endmodule
`default_nettype wire

/* File: rtl/fp_status_exception_unit.sv */
// Summary of operation
// RULE_01 - Mailbox 0xFD plus null call: read last opcode, write new, return old.
// RULE_02 - Release the coprocessor lock before reading the last opcode.
// RULE_03 - Mailbox 0xFC plus null call: return last opcode without writing it.
// RULE_04 - Software saves context, fetching the opcode with 0xFC when pending.
// RULE_05 - Software restores context, then swaps the opcode in with 0xFD.
// RULE_06 - Untrapped condition writes default result; trapped one raises an interrupt.
// RULE_07 - Every register set owns a separate status word.
// RULE_08 - Bit 1 is the OR of flag bits 2, 4, 6, 8 and 25.
// RULE_09 - Flag and enable pairs: 2/3, 4/5, 6/7, 8/9, 25/26.
// RULE_10 - Bit 18 flags bus parity; bit 19 flags a pending exception.
// RULE_11 - Bits 23-24 select nearest, zero, plus or minus infinity rounding.
// RULE_12 - Bit 27 is held zero and bit 28 held one on writes.
// RULE_13 - Bits 29-31 report the last operation code.
// RULE_14 - With bit 0 clear no interrupt is raised.
// RULE_15 - Bit 0 and an occurring enabled condition interrupt, then clear bit 0.
// RULE_16 - Untrapped divide-by-zero sets bits 1 and 4 and leaves signed infinity.
// RULE_17 - Software uses only the read and write status commands.
// RULE_18 - Software writes reserved fields back unchanged after reading them.
// RULE_19 - Every generated not-a-number is quiet.
// RULE_20 - Report an error for absent or locked unit, privileged or bad access, no emulation.
// RULE_21 - Flags stay set until a status write clears them.
`default_nettype none
module fp_status_exception_unit
    import fpse_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             accel_advanced,
    input  wire logic             status_wr_en,
    input  wire logic [SET_W-1:0] status_wr_set,
    input  wire logic [31:0]      status_wr_data,
    input  wire logic             status_rd_en,
    input  wire logic [SET_W-1:0] status_rd_set,
    output logic      [31:0]      status_rd_data,
    output logic                  status_rd_valid,
    input  wire logic             op_valid,
    input  wire logic [SET_W-1:0] op_set,
    input  wire logic [2:0]       op_code,
    input  wire logic             op_sign,
    input  wire logic             op_cmp_valid,
    input  wire logic [1:0]       op_cmp,
    input  wire logic [31:0]      op_raw_result,
    input  wire logic [5:0]       op_dest,
    input  wire logic             parity_event,
    input  wire logic [SET_W-1:0] parity_set,
    input  wire logic             cop_present,
    input  wire logic             cop_locked,
    input  wire logic             op_privileged,
    input  wire logic             op_load_store,
    input  wire logic             emul_present,
    output logic                  result_wr_en,
    output logic      [31:0]      result_data,
    output logic      [5:0]       result_dest,
    output logic                  mc_irq,
    output logic      [SET_W-1:0] mc_irq_set,
    output logic                  fp_error,
    input  wire logic             null_service_call,
    input  wire logic [7:0]       mbox_code,
    input  wire logic [LOP_W-1:0] mbox_opcode_in,
    output logic      [LOP_W-1:0] mbox_opcode_out,
    output logic                  mbox_done,
    output logic                  cop_unlock,
    output logic                  lop_rd_en,
    input  wire logic [LOP_W-1:0] lop_rd_data,
    output logic                  lop_wr_en,
    output logic      [LOP_W-1:0] lop_wr_data
);
    // One-hot mask of the flag bit that a last-operation code sets.
    function automatic logic [31:0] flag_mask(input logic [2:0] code);
        case (code)
            LOP_INVALID: flag_mask = 32'h0000_0001 << ST_INV;
            LOP_DIVZ:    flag_mask = 32'h0000_0001 << ST_DZ;
            LOP_OVER:    flag_mask = 32'h0000_0001 << ST_OV;
            LOP_UNDER:   flag_mask = 32'h0000_0001 << ST_UN;
            LOP_INEXACT: flag_mask = 32'h0000_0001 << ST_IX;
            default:     flag_mask = 32'h0000_0000;
        endcase
    endfunction

    // Next status word of one set given a write and an operation event.
    function automatic logic [31:0] next_stat(
        input logic [31:0] cur,
        input logic        wr,
        input logic [31:0] wdata,
        input logic        ev,
        input logic [2:0]  code,
        input logic        cmpv,
        input logic [1:0]  cmp,
        input logic        par
    );
        logic [31:0] s;
        logic [31:0] fm;
        s  = wr ? wdata : cur;                                   // RULE_21
        fm = flag_mask(code);
        if (ev) begin
            if (s[ST_MASTER] && |(s & (fm << 1))) begin         // RULE_09
                s[ST_PENDING] = 1'b1;                           // RULE_10
                s[ST_MASTER]  = 1'b0;                           // RULE_15
            end
            s = s | fm;                                          // RULE_21
            s[ST_LOP_HI:ST_LOP_LO] = code;                       // RULE_13
            if (cmpv) begin
                s[ST_CMP_HI:ST_CMP_LO] = cmp;
            end
        end
        if (par) begin
            s[ST_PARITY] = 1'b1;                                 // RULE_10
        end
        s[ST_SUMMARY] = |(s & FLAG_BITS);                        // RULE_08
        s[ST_ZERO]    = 1'b0;                                    // RULE_12
        s[ST_ONE]     = 1'b1;                                    // RULE_12
        next_stat = s;
    endfunction

    logic [31:0]      status_q [NUM_SETS];
    logic [31:0]      next_status [NUM_SETS];
    fpse_mbox_t       mbox_state;
    fpse_mbox_t       next_mbox_state;
    logic             mbox_swap;
    logic [LOP_W-1:0] mbox_new_opcode;

    // Operation screening: errors stop the operation from touching status.
    wire        op_fault  = !cop_present || cop_locked || op_privileged ||
                            !op_load_store || !emul_present;             // RULE_20
    wire        op_ok     = op_valid && !op_fault;
    wire [2:0]  eff_code  = ((op_code == LOP_DMAPAR) && !accel_advanced)
                          ? LOP_ILLEGAL : op_code;                        // RULE_13
    wire [31:0] op_fmask  = flag_mask(eff_code);
    wire        op_same   = status_wr_en && (status_wr_set == op_set);
    wire [31:0] op_base   = op_same ? status_wr_data : status_q[op_set];
    wire        op_cond   = |op_fmask;
    wire        op_trap   = op_ok && op_cond && op_base[ST_MASTER] &&
                            |(op_base & (op_fmask << 1));                 // RULE_14
    wire        op_untrap = op_ok && op_cond && !op_trap;
    wire [1:0]  op_rnd    = op_base[ST_RND_HI:ST_RND_LO];                 // RULE_11
    wire [31:0] dflt_result;

    // Default result generation for untrapped conditions.
    fpse_default_result u_default (
        .op_code        (eff_code),
        .op_sign        (op_sign),
        .rnd_mode       (op_rnd),
        .raw_result     (op_raw_result),
        .default_result (dflt_result)
    );

    // One status word per register set.
    genvar g;
    generate
        for (g = 0; g < NUM_SETS; g = g + 1) begin : g_set
            assign next_status[g] = next_stat(status_q[g],
                status_wr_en && (status_wr_set == g), status_wr_data,
                op_ok && (op_set == g), eff_code, op_cmp_valid, op_cmp,
                parity_event && (parity_set == g));                       // RULE_07
            always_ff @(posedge mclk) begin
                if (reset) begin
                    status_q[g] <= STATUS_RESET;
                end else begin
                    status_q[g] <= next_status[g];
                end
            end
        end
    endgenerate

    // Status read command returns the stored word one cycle later.
    always_ff @(posedge mclk) begin
        if (reset) begin
            status_rd_data  <= STATUS_RESET;
            status_rd_valid <= 1'b0;
        end else begin
            status_rd_valid <= status_rd_en;
            if (status_rd_en) begin
                status_rd_data <= status_q[status_rd_set];
            end
        end
    end

    // Result write, interrupt and error reporting for each operation.
    always_ff @(posedge mclk) begin
        if (reset) begin
            result_wr_en <= 1'b0;
            result_data  <= 32'h0000_0000;
            result_dest  <= 6'h00;
            mc_irq       <= 1'b0;
            mc_irq_set   <= 4'h0;
            fp_error     <= 1'b0;
        end else begin
            result_wr_en <= op_untrap;                                    // RULE_06
            mc_irq       <= op_trap;                                      // RULE_15
            fp_error     <= op_valid && op_fault;                         // RULE_20
            if (op_untrap) begin
                result_data <= dflt_result;                               // RULE_16
                result_dest <= op_dest;
            end
            if (op_trap) begin
                mc_irq_set <= op_set;
            end
        end
    end

    // Mailbox sequencer: optional unlock, read, optional write, answer.
    wire mbox_req = null_service_call &&
                    ((mbox_code == MBOX_SWAP) || (mbox_code == MBOX_FETCH));
    always_comb begin
        next_mbox_state = mbox_state;
        case (mbox_state)
            FPSE_IDLE: begin
                if (mbox_req) begin
                    next_mbox_state = cop_locked ? FPSE_UNLOCK : FPSE_READ;  // RULE_02
                end
            end
            FPSE_UNLOCK: next_mbox_state = FPSE_READ;
            FPSE_READ:   next_mbox_state = FPSE_CAPT;
            FPSE_CAPT:   next_mbox_state = FPSE_DONE;
            FPSE_DONE:   next_mbox_state = FPSE_IDLE;
            default:     next_mbox_state = FPSE_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mbox_state <= FPSE_IDLE;
        end else begin
            mbox_state <= next_mbox_state;
        end
    end

    // Latch the request so page-zero inputs may change while busy.
    always_ff @(posedge mclk) begin
        if (reset) begin
            mbox_swap       <= 1'b0;
            mbox_new_opcode <= 16'h0000;
        end else if ((mbox_state == FPSE_IDLE) && mbox_req) begin
            mbox_swap       <= (mbox_code == MBOX_SWAP);
            mbox_new_opcode <= mbox_opcode_in;
        end
    end

    // Coprocessor strobes and the returned opcode.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cop_unlock      <= 1'b0;
            lop_rd_en       <= 1'b0;
            lop_wr_en       <= 1'b0;
            lop_wr_data     <= 16'h0000;
            mbox_opcode_out <= 16'h0000;
            mbox_done       <= 1'b0;
        end else begin
            cop_unlock <= (mbox_state == FPSE_IDLE) && mbox_req && cop_locked;  // RULE_02
            lop_rd_en  <= next_mbox_state == FPSE_READ && mbox_state != FPSE_READ;
            lop_wr_en  <= (mbox_state == FPSE_READ) && mbox_swap;         // RULE_01
            mbox_done  <= mbox_state == FPSE_CAPT;
            if (mbox_state == FPSE_READ) begin
                lop_wr_data <= mbox_new_opcode;                           // RULE_01
            end
            if (mbox_state == FPSE_CAPT) begin
                mbox_opcode_out <= lop_rd_data;                           // RULE_03
            end
        end
    end

    a_summary_bit: assert property (@(posedge mclk) disable iff (reset)
        status_rd_valid |-> status_rd_data[ST_SUMMARY] == |(status_rd_data & FLAG_BITS))
        else $error("summary bit differs from flag OR");  // RULE_08
    a_fixed_bits: assert property (@(posedge mclk) disable iff (reset)
        status_rd_valid |-> !status_rd_data[ST_ZERO] && status_rd_data[ST_ONE])
        else $error("fixed status bits wrong");  // RULE_12
    a_irq_needs_master: assert property (@(posedge mclk) disable iff (reset)
        mc_irq |-> $past(op_base[ST_MASTER]) && $past(op_valid))
        else $error("interrupt without master enable");  // RULE_14
    a_irq_clears_master: assert property (@(posedge mclk) disable iff (reset)
        mc_irq |-> !status_q[mc_irq_set][ST_MASTER] && status_q[mc_irq_set][ST_PENDING])
        else $error("master bit not cleared after interrupt");  // RULE_15
    a_untrap_result: assert property (@(posedge mclk) disable iff (reset)
        op_untrap |=> result_wr_en && !mc_irq)
        else $error("untrapped condition wrote no result");  // RULE_06
    a_divz_infinity: assert property (@(posedge mclk) disable iff (reset)
        op_untrap && (eff_code == LOP_DIVZ) |=> result_data[30:0] == FP_INF[30:0]
            && status_q[$past(op_set)][ST_DZ] && status_q[$past(op_set)][ST_SUMMARY])
        else $error("divide-by-zero default wrong");  // RULE_16
    a_quiet_nan: assert property (@(posedge mclk) disable iff (reset)
        result_wr_en && (result_data[30:23] == FP_EXP_MAX) && (result_data[22:0] != 0)
            |-> result_data[FP_QUIET_BIT])
        else $error("signalling NaN generated");  // RULE_19
    a_error_report: assert property (@(posedge mclk) disable iff (reset)
        op_valid && !cop_present |=> fp_error && !result_wr_en && !mc_irq)
        else $error("absent unit not reported");  // RULE_20
    a_unlock_first: assert property (@(posedge mclk) disable iff (reset)
        (mbox_state == FPSE_IDLE) && mbox_req && cop_locked |=> cop_unlock ##1 lop_rd_en)
        else $error("read before unlock");  // RULE_02
    a_fetch_no_write: assert property (@(posedge mclk) disable iff (reset)
        (mbox_state == FPSE_IDLE) && mbox_req && (mbox_code == MBOX_FETCH)
            |-> !lop_wr_en [*5])
        else $error("fetch request wrote the opcode");  // RULE_03
    a_swap_done: assert property (@(posedge mclk) disable iff (reset)
        (mbox_state == FPSE_IDLE) && mbox_req && !cop_locked && (mbox_code == MBOX_SWAP)
            |-> ##2 lop_wr_en ##1 mbox_done)
        else $error("swap sequence out of step");  // RULE_01
    a_sticky_flag: assert property (@(posedge mclk) disable iff (reset)
        status_q[1][ST_DZ] && !(status_wr_en && (status_wr_set == 1)) |=> status_q[1][ST_DZ])
        else $error("sticky flag lost");  // RULE_21
endmodule
`default_nettype wire

/* File: rtl/fpse_default_result.sv */
`default_nettype none
module fpse_default_result
    import fpse_pkg::*;
(
    input  wire logic [2:0]  op_code,
    input  wire logic        op_sign,
    input  wire logic [1:0]  rnd_mode,
    input  wire logic [31:0] raw_result,
    output logic      [31:0] default_result
);
    logic [31:0] chosen;
    logic [31:0] ovf_mag;

    // Overflow magnitude follows the rounding mode and the sign.
    assign ovf_mag = (rnd_mode == RND_NEAREST) ? FP_INF :
                     (rnd_mode == RND_ZERO)    ? FP_MAXF :
                     (rnd_mode == RND_PINF)    ? (op_sign ? FP_MAXF : FP_INF) :
                                                 (op_sign ? FP_INF : FP_MAXF);

    // Standard default result for each untrapped condition.
    assign chosen = (op_code == LOP_DIVZ)    ? {op_sign, FP_INF[30:0]} :  // RULE_16
                    (op_code == LOP_INVALID) ? FP_QNAN :
                    (op_code == LOP_OVER)    ? {op_sign, ovf_mag[30:0]} :
                    (op_code == LOP_UNDER)   ? {op_sign, 31'h0000_0000} :
                                               raw_result;

    // Any not-a-number leaving here is forced quiet.
    assign default_result = ((chosen[30:23] == FP_EXP_MAX) && (chosen[22:0] != 23'h000000))
                          ? (chosen | (32'h0000_0001 << FP_QUIET_BIT)) : chosen;  // RULE_19
endmodule
`default_nettype wire

/* File: rtl/fpse_pkg.sv */
`default_nettype none
package fpse_pkg;
    // Page-zero mailbox locations and command codes.
    localparam logic [7:0]  PZ_MBOX_ADDR   = 8'hD7;
    localparam logic [7:0]  PZ_OPCODE_ADDR = 8'hC8;
    localparam logic [7:0]  MBOX_SWAP      = 8'hFD;
    localparam logic [7:0]  MBOX_FETCH     = 8'hFC;
    // Register set geometry.
    localparam int          NUM_SETS       = 16;
    localparam int          SET_W          = 4;
    localparam int          BASIC_GPRS     = 16;
    localparam int          ADV_GPRS       = 64;
    localparam int          LOP_W          = 16;
    // Status word field positions, bit 0 is the least significant bit.
    localparam int          ST_MASTER      = 0;
    localparam int          ST_SUMMARY     = 1;
    localparam int          ST_PARITY      = 18;
    localparam int          ST_PENDING     = 19;
    localparam int          ST_CMP_LO      = 21;
    localparam int          ST_CMP_HI      = 22;
    localparam int          ST_RND_LO      = 23;
    localparam int          ST_RND_HI      = 24;
    localparam int          ST_ZERO        = 27;
    localparam int          ST_ONE         = 28;
    localparam int          ST_LOP_LO      = 29;
    localparam int          ST_LOP_HI      = 31;
    localparam int          ST_INV         = 2;
    localparam int          ST_DZ          = 4;
    localparam int          ST_OV          = 6;
    localparam int          ST_UN          = 8;
    localparam int          ST_IX          = 25;
    localparam logic [31:0] FLAG_BITS      = 32'h0200_0154;
    localparam logic [31:0] STATUS_RESET   = 32'h1000_0000;
    // Last-operation codes.
    localparam logic [2:0]  LOP_NONE       = 3'h0;
    localparam logic [2:0]  LOP_UNDER      = 3'h1;
    localparam logic [2:0]  LOP_OVER       = 3'h2;
    localparam logic [2:0]  LOP_DIVZ       = 3'h3;
    localparam logic [2:0]  LOP_DMAPAR     = 3'h4;
    localparam logic [2:0]  LOP_INVALID    = 3'h5;
    localparam logic [2:0]  LOP_INEXACT    = 3'h6;
    localparam logic [2:0]  LOP_ILLEGAL    = 3'h7;
    // Rounding modes.
    localparam logic [1:0]  RND_NEAREST    = 2'h0;
    localparam logic [1:0]  RND_ZERO       = 2'h1;
    localparam logic [1:0]  RND_PINF       = 2'h2;
    localparam logic [1:0]  RND_MINF       = 2'h3;
    // Single-precision default results.
    localparam logic [31:0] FP_INF         = 32'h7F80_0000;
    localparam logic [31:0] FP_MAXF        = 32'h7F7F_FFFF;
    localparam logic [31:0] FP_QNAN        = 32'h7FC0_0000;
    localparam logic [7:0]  FP_EXP_MAX     = 8'hFF;
    localparam int          FP_QUIET_BIT   = 22;
    // Mailbox sequencer states, Gray coded along the path.
    typedef enum logic [2:0] {
        FPSE_IDLE   = 3'b000,
        FPSE_UNLOCK = 3'b001,
        FPSE_READ   = 3'b011,
        FPSE_CAPT   = 3'b010,
        FPSE_DONE   = 3'b110
    } fpse_mbox_t;
endpackage
`default_nettype wire
